// File: hdl/ezs_interlock.sv
/*
 * Front-panel input logic: node address capture from two hex rotary switches
 * and the interlocked extension push switch sequencer, with AXI4-Lite registers.
 * Assumes aresetn is asserted at control power-up and all pins are synchronous.
 */
`timescale 1ns/1ps
module ezs_interlock #(
	parameter int TICK_CYCLES = ezs_pkg::TICK_CYCLES,
	parameter int DEB_CYCLES  = ezs_pkg::DEB_CYCLES,
	parameter int N_FUNC      = 128
)(
	input  wire logic                       aclk,
	input  wire logic                       aresetn,
	input  wire logic [ezs_pkg::ADDR_W-1:0] s_axi_awaddr,
	input  wire logic                       s_axi_awvalid,
	output logic                            s_axi_awready,
	input  wire logic [31:0]                s_axi_wdata,
	input  wire logic [3:0]                 s_axi_wstrb,
	input  wire logic                       s_axi_wvalid,
	output logic                            s_axi_wready,
	output logic [1:0]                      s_axi_bresp,
	output logic                            s_axi_bvalid,
	input  wire logic                       s_axi_bready,
	input  wire logic [ezs_pkg::ADDR_W-1:0] s_axi_araddr,
	input  wire logic                       s_axi_arvalid,
	output logic                            s_axi_arready,
	output logic [31:0]                     s_axi_rdata,
	output logic [1:0]                      s_axi_rresp,
	output logic                            s_axi_rvalid,
	input  wire logic                       s_axi_rready,
	input  wire logic [3:0]                 node_id_switch_hi,
	input  wire logic [3:0]                 node_id_switch_lo,
	input  wire logic                       extension_push_switch,
	output logic [7:0]                      node_address,
	output logic                            led_power,
	output logic                            led_alarm,
	output logic                            exec_pulse,
	output logic [N_FUNC-1:0]               func_signals
);
	localparam int TW = $clog2(TICK_CYCLES + 1);
	localparam int W  = ezs_pkg::TIME_W;
	localparam int FW = ezs_pkg::FUNC_W;
	localparam int AW = ezs_pkg::ADDR_W;

	ezs_sw_if sw ();

	logic [FW-1:0]       func_sel_reg;
	logic                invert_reg;
	logic [W-1:0]        hold_reg;
	logic [W-1:0]        dur_reg;
	logic [W-1:0]        mon_reg;
	logic [7:0]          maddr_reg;
	logic [7:0]          sw_latch_reg;
	logic                latched_reg;
	logic [7:0]          node_reg;
	logic [TW-1:0]       tick_cnt_reg;
	logic                tick;
	logic                blink_reg;
	logic [W-1:0]        tmr_reg;
	logic                tmr_clr;
	ezs_pkg::ezs_state_t state_reg;
	ezs_pkg::ezs_state_t state_next;
	logic                exec_next;
	logic                exec_reg;
	logic                func_level;
	logic [N_FUNC-1:0]   func_reg;
	logic                led_power_reg;
	logic                led_alarm_reg;
	logic [AW-1:0]       awaddr_reg;
	logic                aw_full_reg;
	logic [31:0]         wdata_reg;
	logic [3:0]          wstrb_reg;
	logic                w_full_reg;
	logic                bvalid_reg;
	logic [1:0]          bresp_reg;
	logic                rvalid_reg;
	logic [31:0]         rdata_reg;
	logic [1:0]          rresp_reg;
	logic                aw_take;
	logic                w_take;
	logic                ar_take;
	logic                wr_fire;
	logic                wr_hit;
	logic [AW-1:0]       wr_addr;
	logic [31:0]         wr_data;
	logic [3:0]          wr_strb;
	logic [31:0]         wr_mask;
	logic [31:0]         rd_word;
	logic [1:0]          rd_resp;
	logic [31:0]         func_word;
	logic [31:0]         time_word;
	logic [31:0]         maddr_word;
	logic [31:0]         stat_word;
	logic [31:0]         func_new;
	logic [31:0]         time_new;
	logic [31:0]         maddr_new;

	// Switch conditioning
	assign sw.raw = extension_push_switch;

	ezs_debounce #(
		.DEB_CYCLES (DEB_CYCLES)
	) ezs_debounce_inst
	(
		.aclk    (aclk),
		.aresetn (aresetn),
		.sw      (sw)
	);

	// Write channels are held separately so address and data may come in either order
	assign s_axi_awready = !aw_full_reg && !bvalid_reg;
	assign s_axi_wready  = !w_full_reg && !bvalid_reg;
	assign aw_take       = s_axi_awvalid && s_axi_awready;
	assign w_take        = s_axi_wvalid && s_axi_wready;
	assign wr_addr       = aw_full_reg ? awaddr_reg : s_axi_awaddr;
	assign wr_data       = w_full_reg ? wdata_reg : s_axi_wdata;
	assign wr_strb       = w_full_reg ? wstrb_reg : s_axi_wstrb;
	assign wr_fire       = (aw_full_reg || aw_take) && (w_full_reg || w_take);
	assign wr_hit        = (wr_addr == ezs_pkg::OFS_FUNC) || (wr_addr == ezs_pkg::OFS_TIME) ||
	                       (wr_addr == ezs_pkg::OFS_MADDR) || (wr_addr == ezs_pkg::OFS_STAT);

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_full_reg <= 1'b0;
			awaddr_reg  <= '0;
			w_full_reg  <= 1'b0;
			wdata_reg   <= '0;
			wstrb_reg   <= '0;
		end
		else if (wr_fire)
		begin
			aw_full_reg <= 1'b0;
			w_full_reg  <= 1'b0;
		end
		else
		begin
			if (aw_take)
			begin
				aw_full_reg <= 1'b1;
				awaddr_reg  <= s_axi_awaddr;
			end
			if (w_take)
			begin
				w_full_reg <= 1'b1;
				wdata_reg  <= s_axi_wdata;
				wstrb_reg  <= s_axi_wstrb;
			end
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			bvalid_reg <= 1'b0;
			bresp_reg  <= ezs_pkg::RESP_OKAY;
		end
		else if (wr_fire)
		begin
			bvalid_reg <= 1'b1;
			bresp_reg  <= wr_hit ? ezs_pkg::RESP_OKAY : ezs_pkg::RESP_DECERR;
		end
		else if (s_axi_bready)
			bvalid_reg <= 1'b0;
	end

	assign s_axi_bvalid = bvalid_reg;
	assign s_axi_bresp  = bresp_reg;

	for (genvar g = 0; g < 4; g++)
	begin : g_lane
		assign wr_mask[8*g +: 8] = {8{wr_strb[g]}};
	end

	// Register images, shared by read mux and byte-merge on write
	always_comb
	begin
		func_word  = '0;
		time_word  = '0;
		maddr_word = '0;
		stat_word  = '0;
		func_word[ezs_pkg::FUNC_LSB +: FW] = func_sel_reg;
		func_word[ezs_pkg::INV_BIT]        = invert_reg;
		time_word[ezs_pkg::HOLD_LSB +: W]  = hold_reg;
		time_word[ezs_pkg::DUR_LSB +: W]   = dur_reg;
		time_word[ezs_pkg::MON_LSB +: W]   = mon_reg;
		maddr_word[7:0]                    = maddr_reg;
		stat_word[ezs_pkg::NODE_LSB +: 8]  = node_reg;
		stat_word[ezs_pkg::SW_LSB +: 8]    = sw_latch_reg;
		stat_word[ezs_pkg::STATE_LSB +: 5] = state_reg;
	end

	assign func_new  = (func_word & ~wr_mask) | (wr_data & wr_mask);
	assign time_new  = (time_word & ~wr_mask) | (wr_data & wr_mask);
	assign maddr_new = (maddr_word & ~wr_mask) | (wr_data & wr_mask);

	// Settings take effect at once; a change mid-sequence alters the limit the running timer is compared against
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			func_sel_reg <= ezs_pkg::FUNC_RST;
			invert_reg   <= ezs_pkg::INV_RST;
			hold_reg     <= ezs_pkg::HOLD_RST;
			dur_reg      <= ezs_pkg::DUR_RST;
			mon_reg      <= ezs_pkg::MON_RST;
			maddr_reg    <= ezs_pkg::MADDR_RST;
		end
		else if (wr_fire)
		begin
			if (wr_addr == ezs_pkg::OFS_FUNC)
			begin
				func_sel_reg <= func_new[ezs_pkg::FUNC_LSB +: FW];
				invert_reg   <= func_new[ezs_pkg::INV_BIT];
			end
			if (wr_addr == ezs_pkg::OFS_TIME)
			begin
				hold_reg <= time_new[ezs_pkg::HOLD_LSB +: W];
				dur_reg  <= time_new[ezs_pkg::DUR_LSB +: W];
				mon_reg  <= time_new[ezs_pkg::MON_LSB +: W];
			end
			if (wr_addr == ezs_pkg::OFS_MADDR)
				maddr_reg <= maddr_new[7:0];
		end
	end

	// Read path
	assign s_axi_arready = !rvalid_reg;
	assign ar_take       = s_axi_arvalid && s_axi_arready;

	always_comb
	begin
		rd_resp = ezs_pkg::RESP_OKAY;
		case (s_axi_araddr)
			ezs_pkg::OFS_FUNC:  rd_word = func_word;
			ezs_pkg::OFS_TIME:  rd_word = time_word;
			ezs_pkg::OFS_MADDR: rd_word = maddr_word;
			ezs_pkg::OFS_STAT:  rd_word = stat_word;
			default:
			begin
				rd_word = '0;
				rd_resp = ezs_pkg::RESP_DECERR;
			end
		endcase
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			rvalid_reg <= 1'b0;
			rdata_reg  <= '0;
			rresp_reg  <= ezs_pkg::RESP_OKAY;
		end
		else if (ar_take)
		begin
			rvalid_reg <= 1'b1;
			rdata_reg  <= rd_word;
			rresp_reg  <= rd_resp;
		end
		else if (s_axi_rready)
			rvalid_reg <= 1'b0;
	end

	assign s_axi_rvalid = rvalid_reg;
	assign s_axi_rdata  = rdata_reg;
	assign s_axi_rresp  = rresp_reg;

	// Switches read once, on the first clock out of every aresetn reset
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			latched_reg  <= 1'b0;
			sw_latch_reg <= '0;
		end
		else if (!latched_reg)
		begin
			latched_reg  <= 1'b1;
			sw_latch_reg <= {node_id_switch_hi, node_id_switch_lo};
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			node_reg <= ezs_pkg::MADDR_RST;
		else if (sw_latch_reg == 8'h00)
			node_reg <= maddr_reg;
		else
			node_reg <= sw_latch_reg;
	end

	assign node_address = node_reg;

	// Tick restarts on each phase except ST_WAIT_PRESS, so those phases last whole ticks
	assign tick    = (tick_cnt_reg == TW'(TICK_CYCLES - 1));
	assign tmr_clr = (state_next != state_reg) && (state_next != ezs_pkg::ST_WAIT_PRESS);

	always_ff @(posedge aclk)
	begin
		if (!aresetn || tmr_clr || tick)
			tick_cnt_reg <= '0;
		else
			tick_cnt_reg <= tick_cnt_reg + 1'b1;
	end

	// Window timer keeps running across the release, so the window is not stretched
	always_ff @(posedge aclk)
	begin
		if (!aresetn || tmr_clr)
			tmr_reg <= '0;
		else if (tick && (tmr_reg != '1))
			tmr_reg <= tmr_reg + 1'b1;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn || tmr_clr)
			blink_reg <= 1'b1;
		else if (tick)
			blink_reg <= !blink_reg;
	end

	// Sequencer
	always_comb
	begin
		state_next = state_reg;
		exec_next  = 1'b0;
		case (state_reg)
			ezs_pkg::ST_LOCKED:
			begin
				if (hold_reg == '0)
				begin
					if (sw.rise)
					begin
						state_next = ezs_pkg::ST_MONITOR;
						exec_next  = 1'b1;
					end
				end
				else if (sw.pressed)
					state_next = ezs_pkg::ST_HOLD;
			end
			ezs_pkg::ST_HOLD:
			begin
				if (!sw.pressed)
					state_next = ezs_pkg::ST_LOCKED;
				else if (tmr_reg >= hold_reg)
					state_next = ezs_pkg::ST_WAIT_REL;
			end
			ezs_pkg::ST_WAIT_REL:
			begin
				if (tmr_reg >= dur_reg)
					state_next = ezs_pkg::ST_LOCKED;
				else if (!sw.pressed)
					state_next = ezs_pkg::ST_WAIT_PRESS;
			end
			ezs_pkg::ST_WAIT_PRESS:
			begin
				if (tmr_reg >= dur_reg)
					state_next = ezs_pkg::ST_LOCKED;
				else if (sw.rise)
				begin
					state_next = ezs_pkg::ST_MONITOR;
					exec_next  = 1'b1;
				end
			end
			ezs_pkg::ST_MONITOR:
			begin
				if (tmr_reg >= mon_reg)
					state_next = ezs_pkg::ST_LOCKED;
			end
			default:
				state_next = ezs_pkg::ST_LOCKED;
		endcase
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			state_reg <= ezs_pkg::ST_LOCKED;
		else
			state_reg <= state_next;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			exec_reg <= 1'b0;
		else
			exec_reg <= exec_next;
	end

	assign exec_pulse = exec_reg;

	// Selected input is high through the monitor phase, or low through it if invert_reg is set; others stay low
	assign func_level = (state_reg == ezs_pkg::ST_MONITOR) ^ invert_reg;

	for (genvar f = 0; f < N_FUNC; f++)
	begin : g_func
		always_ff @(posedge aclk)
		begin
			if (!aresetn)
				func_reg[f] <= 1'b0;
			else
				func_reg[f] <= (func_sel_reg == FW'(f)) && func_level;
		end
	end

	assign func_signals = func_reg;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			led_power_reg <= 1'b1;
			led_alarm_reg <= 1'b0;
		end
		else
		begin
			case (state_reg)
				ezs_pkg::ST_WAIT_REL, ezs_pkg::ST_WAIT_PRESS:
				begin
					led_power_reg <= blink_reg;
					led_alarm_reg <= blink_reg;
				end
				ezs_pkg::ST_MONITOR:
				begin
					led_power_reg <= 1'b1;
					led_alarm_reg <= 1'b1;
				end
				default:
				begin
					led_power_reg <= 1'b1;
					led_alarm_reg <= 1'b0;
				end
			endcase
		end
	end

	assign led_power = led_power_reg;
	assign led_alarm = led_alarm_reg;

	property p_exec_gated;
		@(posedge aclk) disable iff (!aresetn)
		exec_reg |-> ($past(state_reg) == ezs_pkg::ST_WAIT_PRESS) ||
		             (($past(state_reg) == ezs_pkg::ST_LOCKED) && ($past(hold_reg) == '0));
	endproperty
	a_exec_gated: assert property (p_exec_gated) else $error("function fired outside the unlock window");

	property p_mon_leds;
		@(posedge aclk) disable iff (!aresetn)
		(state_reg == ezs_pkg::ST_MONITOR) |=> (led_power && led_alarm);
	endproperty
	a_mon_leds: assert property (p_mon_leds) else $error("both lamps not lit in monitor phase");

	property p_locked_leds;
		@(posedge aclk) disable iff (!aresetn)
		(state_reg == ezs_pkg::ST_LOCKED) |=> (led_power && !led_alarm);
	endproperty
	a_locked_leds: assert property (p_locked_leds) else $error("lamps wrong while locked");

	property p_blink_together;
		@(posedge aclk) disable iff (!aresetn)
		((state_reg == ezs_pkg::ST_WAIT_REL) || (state_reg == ezs_pkg::ST_WAIT_PRESS)) |=> (led_power == led_alarm);
	endproperty
	a_blink_together: assert property (p_blink_together) else $error("lamps not blinking together");

	property p_relock;
		@(posedge aclk) disable iff (!aresetn)
		((state_reg == ezs_pkg::ST_WAIT_PRESS) && (tmr_reg >= dur_reg)) |=> (state_reg == ezs_pkg::ST_LOCKED);
	endproperty
	a_relock: assert property (p_relock) else $error("window expiry did not relock");

	property p_node_frozen;
		@(posedge aclk) disable iff (!aresetn)
		($past(latched_reg) && latched_reg) |-> $stable(sw_latch_reg);
	endproperty
	a_node_frozen: assert property (p_node_frozen) else $error("switch capture changed after power-up");

	c_unlock: cover property (@(posedge aclk) disable iff (!aresetn) state_reg == ezs_pkg::ST_WAIT_REL);
	c_exec: cover property (@(posedge aclk) disable iff (!aresetn) exec_reg);
	c_expire: cover property (@(posedge aclk) disable iff (!aresetn)
		(state_reg == ezs_pkg::ST_WAIT_PRESS) ##1 (state_reg == ezs_pkg::ST_LOCKED));
endmodule

// File: hdl/ezs_pkg.sv
/*
 * Shared constants for the extension switch interlock block: register map,
 * field layout, reset values, timing counts and the sequence state type.
 * Assumes a 100 MHz system clock.
 */
package ezs_pkg;
	localparam int CLK_HZ      = 100_000_000;
	localparam int TICK_MS     = 100;
	localparam int DEB_MS      = 10;
	localparam int TICK_CYCLES = TICK_MS * (CLK_HZ / 1000);
	localparam int DEB_CYCLES  = DEB_MS * (CLK_HZ / 1000);

	localparam int ADDR_W = 4;
	localparam logic [3:0] OFS_FUNC  = 4'h0;
	localparam logic [3:0] OFS_TIME  = 4'h4;
	localparam logic [3:0] OFS_MADDR = 4'h8;
	localparam logic [3:0] OFS_STAT  = 4'hC;

	localparam int FUNC_W    = 7;
	localparam int FUNC_LSB  = 0;
	localparam int INV_BIT   = 8;
	localparam int TIME_W    = 6;
	localparam int HOLD_LSB  = 0;
	localparam int DUR_LSB   = 8;
	localparam int MON_LSB   = 16;
	localparam int NODE_LSB  = 0;
	localparam int SW_LSB    = 8;
	localparam int STATE_LSB = 16;

	localparam logic [FUNC_W-1:0] FUNC_RST = 7'h09;
	localparam logic              INV_RST  = 1'h0;
	localparam logic [TIME_W-1:0] HOLD_RST = 6'h0A;
	localparam logic [TIME_W-1:0] DUR_RST  = 6'h1E;
	localparam logic [TIME_W-1:0] MON_RST  = 6'h0A;
	localparam logic [7:0]        MADDR_RST = 8'h00;

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_DECERR = 2'h3;

	typedef enum logic [4:0] {
		ST_LOCKED     = 5'h01,
		ST_HOLD       = 5'h02,
		ST_WAIT_REL   = 5'h04,
		ST_WAIT_PRESS = 5'h08,
		ST_MONITOR    = 5'h10
	} ezs_state_t;
endpackage

// File: hdl/ezs_sw_if.sv
/*
 * Carrier between the switch conditioner and the interlock sequencer.
 * Assumes all signals are synchronous to the system clock.
 */
`timescale 1ns/1ps
interface ezs_sw_if;
	logic raw;
	logic pressed;
	logic rise;

	modport cond
	(
		input  raw,
		output pressed,
		output rise
	);
	modport user
	(
		output raw,
		input  pressed,
		input  rise
	);
endinterface

// File: hdl/ezs_debounce.sv
/*
 * Push switch conditioner: debounces the raw level and marks the press edge.
 * Assumes the raw input is already synchronous to aclk.
 */
`timescale 1ns/1ps
module ezs_debounce #(
	parameter int DEB_CYCLES = ezs_pkg::DEB_CYCLES
)(
	input  wire logic aclk,
	input  wire logic aresetn,
	ezs_sw_if.cond    sw
);
	localparam int CW = $clog2(DEB_CYCLES + 1);

	logic [CW-1:0] cnt_reg;
	logic          pressed_reg;
	logic          rise_reg;

	// Level must differ for the full count before it is accepted
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			cnt_reg     <= '0;
			pressed_reg <= 1'b0;
			rise_reg    <= 1'b0;
		end
		else
		begin
			rise_reg <= 1'b0;
			if (sw.raw == pressed_reg)
				cnt_reg <= '0;
			else if (cnt_reg >= CW'(DEB_CYCLES - 1))
			begin
				cnt_reg     <= '0;
				pressed_reg <= sw.raw;
				rise_reg    <= sw.raw;
			end
			else
				cnt_reg <= cnt_reg + 1'b1;
		end
	end

	assign sw.pressed = pressed_reg;
	assign sw.rise    = rise_reg;

	property p_deb_stable;
		@(posedge aclk) disable iff (!aresetn)
		$changed(pressed_reg) |-> $past(sw.raw) == pressed_reg;
	endproperty
	a_deb_stable: assert property (p_deb_stable) else $error("debounced level taken from wrong raw level");
endmodule

// File: sim/ezs_operator.sv
/* Operator at the panel: presses and releases the push switch.
   Assumes calls start just after a rising aclk edge. */
`timescale 1ns/1ps
module ezs_operator
(
	input  wire logic aclk,
	output logic      pressed
);
	initial pressed = 1'b0;
	// Held level, then released level, counted in clocks
	task automatic push(input int hi, input int lo);
		pressed <= 1'b1;
		repeat (hi) @(posedge aclk);
		pressed <= 1'b0;
		repeat (lo) @(posedge aclk);
	endtask
endmodule

// File: sim/tb_ext_switch_interlock.sv
/* Self-checking bench for the switch interlock: AXI4-Lite tasks, panel push.
   Assumes a short tick (20 clocks) so the sequence stays brief. */
`timescale 1ns/1ps
module tb_ext_switch_interlock;
	logic aclk = 1'b0, aresetn = 1'b0;
	logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hF;
	logic [3:0] node_id_switch_hi = 4'h3, node_id_switch_lo = 4'hA;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, extension_push_switch;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic led_power, led_alarm, exec_pulse;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [7:0] node_address;
	logic [127:0] func_signals;
	int fails = 0, cmp_count = 0, cyc = 0, n_exec = 0;
	ezs_interlock #(.TICK_CYCLES(20), .DEB_CYCLES(4)) ezs_interlock_inst (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .node_id_switch_hi(node_id_switch_hi),
		.node_id_switch_lo(node_id_switch_lo), .extension_push_switch(extension_push_switch),
		.node_address(node_address), .led_power(led_power), .led_alarm(led_alarm),
		.exec_pulse(exec_pulse), .func_signals(func_signals));
	ezs_operator ezs_operator_inst (.aclk(aclk), .pressed(extension_push_switch));
	initial forever #5 aclk = ~aclk;
	always @(posedge aclk)
	begin
		cyc++;
		if (exec_pulse === 1'b1) n_exec++;
		if (cyc == 20000)
		begin
			fails++;
			tally_and_finish;
		end
	end
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		cmp_count++;
		if (g !== e)
		begin
			fails++;
			$display("wrong value t=%0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end
		while (s_axi_bvalid !== 1'b1);
		s_axi_bready <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, input logic [31:0] e);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end
		while (s_axi_rvalid !== 1'b1);
		s_axi_rready <= 1'b0;
		chk(s_axi_rdata, e);
	endtask
	task automatic tally_and_finish;
		$display("compares %0d mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	initial
	begin
		repeat (12) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		node_id_switch_lo <= 4'h5;
		rd(ezs_pkg::OFS_FUNC, 32'h9);
		rd(ezs_pkg::OFS_TIME, 32'h000A1E0A);
		chk(node_address, 8'h3A);
		$display("test defaults done");
		// Too short for the default hold, so both presses must be ignored
		ezs_operator_inst.push(100, 10);
		ezs_operator_inst.push(20, 300);
		chk(n_exec, 0);
		wr(ezs_pkg::OFS_TIME, 32'h00020302);
		rd(ezs_pkg::OFS_TIME, 32'h00020302);
		ezs_operator_inst.push(70, 10);
		ezs_operator_inst.push(10, 5);
		chk(n_exec, 1);
		chk({led_power, led_alarm}, 2'b11);
		chk(func_signals[31:0], 32'h00000200);
		repeat (80) @(posedge aclk);
		chk({led_power, led_alarm}, 2'b10);
		chk(func_signals[31:0], 32'h00000000);
		ezs_operator_inst.push(70, 120);
		ezs_operator_inst.push(10, 5);
		chk(n_exec, 1);
		chk({led_power, led_alarm}, 2'b10);
		wr(ezs_pkg::OFS_FUNC, 32'h00000109);
		@(posedge aclk);
		chk(func_signals[31:0], 32'h00000200);
		$display("test sequence done");
		node_id_switch_hi <= 4'h0;
		node_id_switch_lo <= 4'h0;
		aresetn <= 1'b0;
		repeat (12) @(posedge aclk);
		aresetn <= 1'b1;
		wr(ezs_pkg::OFS_MADDR, 32'h21);
		@(posedge aclk);
		chk(node_address, 8'h21);
		$display("test master address done");
		tally_and_finish;
	end
endmodule
